// *** rtl/fcd_deser_map.vh ***
// constants of the fast command deserializer: timing, bit positions, reset values
// assumes inclusion by each file that uses its macros, before any module
`ifndef FCD_DESER_MAP_VH
`define FCD_DESER_MAP_VH

// clock rates: the bit clock is clk, the main clock is four of its periods
`define FCD_CLK_NS 50
`define FCD_MAIN_NS 200
`define FCD_WORD_CLKS (`FCD_MAIN_NS / `FCD_CLK_NS)
`define FCD_BITS_PER_WORD 8

// programmable delay range in main clock cycles
`define FCD_DELAY_MAX 255
`define FCD_DELAY_W 8

// command word bit positions
`define FCD_CMD_CALIB 7
`define FCD_CMD_SYNC 6
`define FCD_CMD_SNAP 5
`define FCD_CMD_VETO 4
`define FCD_CMD_NOSUPP 3
`define FCD_CMD_HDRONLY 2
`define FCD_CMD_FERESET 1
`define FCD_CMD_BXRESET 0

// reset values and counter widths
`define FCD_TERM_RST 1'b0
`define FCD_WORD_RST 8'h00
`define FCD_BXID_W 12
`define FCD_CNT_W 32

// buffering in the command path and number of phase taps
`define FCD_FIFO_DEPTH 16
`define FCD_PHASES 4

`endif

// *** rtl/fcd_phase_sync.v ***
// one phase synchronisation path: phase tap select, then retime on either clock edge
// assumes taps are the line sampled by the phase clocks, already in the clk domain
`timescale 1ns/10ps
`default_nettype none
module fcd_phase_sync #(
  parameter NPH = 4,
  parameter SW = 2
) (
  input wire clk, // bit clock
  input wire arst_n, // async reset, active low
  input wire [NPH-1:0] taps, // line sampled at each phase
  input wire [SW-1:0] phaseSel, // chosen phase clock
  input wire edgeSel, // 1 takes the falling-edge retimer
  output reg bitOut_ff // retimed bit
);
  reg tap_ff;
  reg pos_ff;
  reg neg_ff;

  // input flop on the selected phase [RULE4]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_ff <= 1'b0;
    end else begin
      tap_ff <= taps[phaseSel];
    end
  end

  // two retimers on opposite edges, so one of them always meets timing [RULE5]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pos_ff <= 1'b0;
    end else begin
      pos_ff <= tap_ff;
    end
  end

  always @(negedge clk or negedge arst_n) begin
    if (!arst_n) begin
      neg_ff <= 1'b0;
    end else begin
      neg_ff <= tap_ff;
    end
  end

  // edge select picks the retimer output [RULE5]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bitOut_ff <= 1'b0;
    end else begin
      bitOut_ff <= edgeSel ? neg_ff : pos_ff;
    end
  end
endmodule // fcd_phase_sync
`default_nettype wire

// *** rtl/fcd_fifo.v ***
// synchronous FIFO with valid/ready on both sides and a flush
// assumes one clock; flush drops all entries in one cycle
`timescale 1ns/10ps
`default_nettype none
module fcd_fifo #(
  parameter W = 8,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk, // clock
  input wire arst_n, // async reset, active low
  input wire flush, // empties the buffer
  input wire [W-1:0] inData, // word to store
  input wire inValid, // word offered
  output wire inReady, // room for a word
  output reg [W-1:0] outData, // head word
  output wire outValid, // head word present
  input wire outReady // drain accepts head
);
  reg [W-1:0] mem [0:D-1];
  reg [AW-1:0] wp_ff;
  reg [AW-1:0] rp_ff;
  reg [AW:0] cnt_ff;
  wire push;
  wire pop;

  assign inReady = (cnt_ff != D[AW:0]);
  assign outValid = (cnt_ff != {(AW+1){1'b0}});
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // head word is read straight from the array
  always @* begin
    outData = mem[rp_ff];
  end

  // storage has no reset, only pointers and fill level do
  always @(posedge clk) begin
    if (push) begin
      mem[wp_ff] <= inData;
    end
  end

  // pointers and fill level
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wp_ff <= {AW{1'b0}};
      rp_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else if (flush) begin
      wp_ff <= {AW{1'b0}};
      rp_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (pop) begin
        rp_ff <= rp_ff + 1'b1;
      end
      if (push && !pop) begin
        cnt_ff <= cnt_ff + 1'b1;
      end else if (pop && !push) begin
        cnt_ff <= cnt_ff - 1'b1;
      end
    end
  end
endmodule // fcd_fifo
`default_nettype wire

// *** rtl/fcd_deserializer.v ***
// fast command deserializer: phase align, byte align, delay and decode commands
// assumes clk is the bit clock; the main clock cycle is four clk periods,
// and the phase taps arrive already sampled in the clk domain
`timescale 1ns/10ps
`default_nettype none
`include "fcd_deser_map.vh"

// How it works
// RULE1 - one new command byte every main cycle
// RULE2 - DDR sampling, first received bit is MSB
// RULE3 - separate rising and falling phase paths
// RULE4 - per-path phase clock chosen by configuration
// RULE5 - two opposite-edge retimers, edge select picks
// RULE6 - byte alignment setting picks first bit
// RULE7 - command delay programmable from 0 to 255
// RULE8 - separate calibration delay drives test pulse
// RULE9 - calib delayed in both; command output feeds counters
// RULE10 - bit7 calibration pulse, bit6 sync packet
// RULE11 - bit5 snapshot counters, bit4 veto packet
// RULE12 - bit3 skip zero suppression, bit2 header-only
// RULE13 - bit1 resets registers/buffers, bit0 resets crossing id
// RULE14 - controller aligns via loopback through serializer
// RULE15 - one bit switches all terminations, off at reset
// RULE16 - eight bits per main cycle, DDR at 4x
// RULE17 - each command bit strobes one main cycle
module fcd_deserializer #(
  parameter NPH = `FCD_PHASES,
  parameter SW = 2,
  parameter FIFO_DEPTH = `FCD_FIFO_DEPTH,
  parameter FIFO_AW = 4
) (
  input wire clk, // bit clock, 20 MHz
  input wire arst_n, // async reset, active low
  input wire [NPH-1:0] riseTaps, // line at each phase, rising-edge bit slot
  input wire [NPH-1:0] fallTaps, // line at each phase, falling-edge bit slot
  input wire [SW-1:0] risePhaseSel, // phase clock for the rising path
  input wire [SW-1:0] fallPhaseSel, // phase clock for the falling path
  input wire riseEdgeSel, // retimer choice, rising path
  input wire fallEdgeSel, // retimer choice, falling path
  input wire [2:0] byteStart, // bit that opens a byte
  input wire [7:0] cmdDelay, // command delay, main cycles
  input wire [7:0] calDelay, // calibration delay, main cycles
  input wire termCfg, // termination enable setting
  input wire ovfClear, // clears the overflow flag
  input wire cmdReady, // processing side takes a buffered word
  output reg termOn_ff, // termination on, all receivers
  output reg [7:0] loopWord_ff, // raw byte for serializer loopback
  output reg mainTick_ff, // marks the first clk of a main cycle
  output reg calibStb_ff, // calibration command strobe
  output reg syncStb_ff, // sync packet request
  output reg snapStb_ff, // snapshot request
  output reg vetoStb_ff, // crossing-veto packet request
  output reg noSuppStb_ff, // skip zero suppression
  output reg hdrOnlyStb_ff, // header-only packet request
  output reg feResetStb_ff, // register reset and buffer flush
  output reg bxResetStb_ff, // crossing id reset
  output reg testPulse_ff, // to test-pulse generator
  output wire [7:0] cmdData, // buffered command word
  output wire cmdValid, // buffered word present
  output reg overflow_ff, // a word was lost to a full buffer
  output reg [`FCD_BXID_W-1:0] bxid_ff, // crossing id counter
  output reg [`FCD_CNT_W-1:0] calibCnt_ff, // calibration commands seen
  output reg [`FCD_CNT_W-1:0] calibSnap_ff, // snapshot of calibration count
  output reg [`FCD_BXID_W-1:0] bxidSnap_ff // snapshot of crossing id
);
  // slot count worked out wide, then cut to the counter's two bits on purpose
  localparam integer LAST_SLOT_I = `FCD_WORD_CLKS - 1;
  localparam [1:0] LAST_SLOT = LAST_SLOT_I[1:0];

  // bit slot counter, one wrap per main cycle
  reg [1:0] slot_ff;
  wire wordTick;
  // retimed bits from the two paths
  wire [1:0] pathBit;
  // bit history for alignment
  reg [15:0] shift_ff;
  wire [15:0] shifted;
  wire [7:0] alignedWord;
  // delay memories
  reg [7:0] cmdMem [0:`FCD_DELAY_MAX];
  reg calMem [0:`FCD_DELAY_MAX];
  reg [`FCD_DELAY_W-1:0] wrPtr_ff;
  wire [`FCD_DELAY_W-1:0] cmdRdIdx;
  wire [`FCD_DELAY_W-1:0] calRdIdx;
  reg [7:0] nxt_cmdWord;
  reg nxt_calBit;
  // delayed word as applied to the processing logic
  reg [7:0] cmdWord_ff;
  reg cmdFresh_ff;
  wire fifoInReady;
  wire fifoFlush;
  wire [SW*2-1:0] phaseSels;
  wire [1:0] edgeSels;
  wire [NPH*2-1:0] allTaps;
  // registered head of the command buffer
  reg [7:0] headWord_ff;
  reg headValid_ff;
  wire [7:0] fifoOutData;
  wire fifoOutValid;
  wire fifoOutReady;

  // main cycle timing from the bit clock [RULE16]
  assign wordTick = (slot_ff == LAST_SLOT);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_ff <= 2'h0;
      mainTick_ff <= 1'b0;
    end else begin
      slot_ff <= slot_ff + 2'h1;
      mainTick_ff <= wordTick;
    end
  end

  // path 1 is the rising edge slot, path 0 the falling one [RULE3]
  assign phaseSels = {risePhaseSel, fallPhaseSel};
  assign edgeSels = {riseEdgeSel, fallEdgeSel};
  assign allTaps = {riseTaps, fallTaps};

  // per path: tap flop on the chosen phase, retimer, output flop [RULE4] [RULE5];
  // the falling-edge retimer is one clk sooner, so flipping edge select moves
  // the byte by two bits and byte alignment has to be searched again
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gPath
      fcd_phase_sync #(
        .NPH(NPH),
        .SW(SW)
      ) uSync (
        .clk(clk),
        .arst_n(arst_n),
        .taps(allTaps[g*NPH +: NPH]),
        .phaseSel(phaseSels[g*SW +: SW]),
        .edgeSel(edgeSels[g]),
        .bitOut_ff(pathBit[g])
      );
    end
  endgenerate

  // two bits per clk, rising-slot bit first, so older bits sit higher [RULE2]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_ff <= 16'h0000;
    end else begin
      shift_ff <= {shift_ff[13:0], pathBit[1], pathBit[0]};
    end
  end

  // alignment offset moves the byte window over the history [RULE6]
  assign shifted = shift_ff >> byteStart;
  assign alignedWord = shifted[7:0];

  // raw byte captured once per main cycle, also looped back [RULE1]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      loopWord_ff <= `FCD_WORD_RST;
    end else if (wordTick) begin
      loopWord_ff <= alignedWord;
    end
  end

  // both delay lines share the write pointer but not the storage [RULE9]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrPtr_ff <= {`FCD_DELAY_W{1'b0}};
    end else if (wordTick) begin
      wrPtr_ff <= wrPtr_ff + 1'b1;
    end
  end

  // storage needs no reset; stale entries only appear while the delay fills
  always @(posedge clk) begin
    if (wordTick) begin
      cmdMem[wrPtr_ff] <= alignedWord;
      calMem[wrPtr_ff] <= alignedWord[`FCD_CMD_CALIB];
    end
  end

  assign cmdRdIdx = wrPtr_ff - cmdDelay;
  assign calRdIdx = wrPtr_ff - calDelay;

  // zero delay bypasses the memory; otherwise read the entry d ticks old [RULE7]
  always @* begin
    nxt_cmdWord = cmdMem[cmdRdIdx];
    if (cmdDelay == 8'h00) begin
      nxt_cmdWord = alignedWord;
    end
  end

  // calibration bit has its own delay setting [RULE8]
  always @* begin
    nxt_calBit = calMem[calRdIdx];
    if (calDelay == 8'h00) begin
      nxt_calBit = alignedWord[`FCD_CMD_CALIB];
    end
  end

  // delayed word held for one main cycle [RULE7] [RULE17]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmdWord_ff <= `FCD_WORD_RST;
      cmdFresh_ff <= 1'b0;
    end else begin
      cmdFresh_ff <= wordTick;
      if (wordTick) begin
        cmdWord_ff <= nxt_cmdWord;
      end
    end
  end

  // calibration delay output goes straight to the pulse generator [RULE8]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      testPulse_ff <= 1'b0;
    end else if (wordTick) begin
      testPulse_ff <= nxt_calBit;
    end
  end

  // decode: each strobe lasts one main cycle, several may be active [RULE17]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      calibStb_ff <= 1'b0;
      syncStb_ff <= 1'b0;
      snapStb_ff <= 1'b0;
      vetoStb_ff <= 1'b0;
      noSuppStb_ff <= 1'b0;
      hdrOnlyStb_ff <= 1'b0;
      feResetStb_ff <= 1'b0;
      bxResetStb_ff <= 1'b0;
    end else if (wordTick) begin
      calibStb_ff <= nxt_cmdWord[`FCD_CMD_CALIB]; // [RULE10]
      syncStb_ff <= nxt_cmdWord[`FCD_CMD_SYNC]; // [RULE10]
      snapStb_ff <= nxt_cmdWord[`FCD_CMD_SNAP]; // [RULE11]
      vetoStb_ff <= nxt_cmdWord[`FCD_CMD_VETO]; // [RULE11]
      noSuppStb_ff <= nxt_cmdWord[`FCD_CMD_NOSUPP]; // [RULE12]
      hdrOnlyStb_ff <= nxt_cmdWord[`FCD_CMD_HDRONLY]; // [RULE12]
      feResetStb_ff <= nxt_cmdWord[`FCD_CMD_FERESET]; // [RULE13]
      bxResetStb_ff <= nxt_cmdWord[`FCD_CMD_BXRESET]; // [RULE13]
    end
  end

  // crossing id counts main cycles and restarts on its reset command [RULE13]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bxid_ff <= {`FCD_BXID_W{1'b0}};
    end else if (wordTick) begin
      if (nxt_cmdWord[`FCD_CMD_BXRESET]) begin
        bxid_ff <= {`FCD_BXID_W{1'b0}};
      end else begin
        bxid_ff <= bxid_ff + 1'b1;
      end
    end
  end

  // calibration counter fed from the command delay output [RULE9]
  // the register-reset command clears the live count, never the snapshot
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      calibCnt_ff <= {`FCD_CNT_W{1'b0}};
    end else if (wordTick) begin
      if (nxt_cmdWord[`FCD_CMD_FERESET]) begin
        calibCnt_ff <= {`FCD_CNT_W{1'b0}}; // [RULE13]
      end else if (nxt_cmdWord[`FCD_CMD_CALIB]) begin
        calibCnt_ff <= calibCnt_ff + 1'b1;
      end
    end
  end

  // snapshot copies the live values as they stood before this command [RULE11]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      calibSnap_ff <= {`FCD_CNT_W{1'b0}};
      bxidSnap_ff <= {`FCD_BXID_W{1'b0}};
    end else if (wordTick && nxt_cmdWord[`FCD_CMD_SNAP]) begin
      calibSnap_ff <= calibCnt_ff;
      bxidSnap_ff <= bxid_ff;
    end
  end

  // the register-reset command also empties the command buffer [RULE13]
  assign fifoFlush = cmdFresh_ff && cmdWord_ff[`FCD_CMD_FERESET];

  // buffer between the delayed stream and the processing logic [RULE9]
  fcd_fifo #(
    .W(8),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) uFifo (
    .clk(clk),
    .arst_n(arst_n),
    .flush(fifoFlush),
    .inData(cmdWord_ff),
    .inValid(cmdFresh_ff),
    .inReady(fifoInReady),
    .outData(fifoOutData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady)
  );

  // one-word output stage keeps the drain's data on flops, not on the array read;
  // it adds one word of room, and the register-reset command empties it too [RULE13]
  assign fifoOutReady = !headValid_ff || cmdReady;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      headWord_ff <= `FCD_WORD_RST;
      headValid_ff <= 1'b0;
    end else if (fifoFlush) begin
      headValid_ff <= 1'b0;
    end else if (fifoOutReady) begin
      headValid_ff <= fifoOutValid;
      if (fifoOutValid) begin
        headWord_ff <= fifoOutData;
      end
    end
  end

  assign cmdData = headWord_ff;
  assign cmdValid = headValid_ff;

  // the stream cannot stall, so a full buffer loses the word; set beats clear
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_ff <= 1'b0;
    end else if (cmdFresh_ff && !fifoInReady && !fifoFlush) begin
      overflow_ff <= 1'b1;
    end else if (ovfClear) begin
      overflow_ff <= 1'b0;
    end
  end

  // single termination control for every receiver, off after reset [RULE15]
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      termOn_ff <= `FCD_TERM_RST;
    end else begin
      termOn_ff <= termCfg;
    end
  end
endmodule // fcd_deserializer
`default_nettype wire

// *** dv/fcd_deser_checker.sv ***
// port assertions for the fast command deserializer
// assumes a single bit clock domain and bind onto the top module
`timescale 1ns/10ps
`default_nettype none
`include "fcd_deser_map.vh"
module fcd_deser_checker (
  input wire logic clk, // bit clock
  input wire logic arst_n, // reset, active low
  input wire logic termCfg, // in
  input wire logic termOn_ff, // in
  input wire logic mainTick_ff, // in
  input wire logic [7:0] loopWord_ff, // in
  input wire logic [7:0] cmdDelay, // in
  input wire logic calibStb_ff, // in
  input wire logic syncStb_ff, // in
  input wire logic snapStb_ff, // in
  input wire logic vetoStb_ff, // in
  input wire logic noSuppStb_ff, // in
  input wire logic hdrOnlyStb_ff, // in
  input wire logic feResetStb_ff, // in
  input wire logic bxResetStb_ff, // in
  input wire logic testPulse_ff, // in
  input wire logic ovfClear, // in
  input wire logic overflow_ff, // in
  input wire logic cmdValid, // in
  input wire logic cmdReady, // in
  input wire logic [`FCD_BXID_W-1:0] bxid_ff // in
);
  // strobes gathered msb first like the command word
  logic [7:0] stbVec;
  assign stbVec = {calibStb_ff, syncStb_ff, snapStb_ff, vetoStb_ff,
    noSuppStb_ff, hdrOnlyStb_ff, feResetStb_ff, bxResetStb_ff};
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_termFollow; 1'b1 |=> termOn_ff == $past(termCfg); endproperty
  a_termFollow: assert property (p_termFollow) else $error("termination mismatch");
  property p_tickPace; mainTick_ff |=> !mainTick_ff [*3] ##1 mainTick_ff; endproperty
  a_tickPace: assert property (p_tickPace) else $error("main tick pace");
  property p_wordHold; !$stable(loopWord_ff) |-> mainTick_ff; endproperty
  a_wordHold: assert property (p_wordHold) else $error("word changed mid cycle");
  property p_stbHold; !$stable(stbVec) |-> mainTick_ff; endproperty
  a_stbHold: assert property (p_stbHold) else $error("strobe changed mid cycle");
  property p_pulseHold; !$stable(testPulse_ff) |-> mainTick_ff; endproperty
  a_pulseHold: assert property (p_pulseHold) else $error("test pulse mid cycle");
  property p_decode0;
    mainTick_ff && cmdDelay == 8'h00 && $past(cmdDelay, 8) == 8'h00 |-> stbVec == loopWord_ff;
  endproperty
  a_decode0: assert property (p_decode0) else $error("undelayed decode");
  property p_ovfSticky; overflow_ff && !ovfClear |=> overflow_ff; endproperty
  a_ovfSticky: assert property (p_ovfSticky) else $error("overflow dropped");
  property p_bxidPace; !$stable(bxid_ff) |=> $stable(bxid_ff) [*3]; endproperty
  a_bxidPace: assert property (p_bxidPace) else $error("crossing id pace");
  property p_holdValid; cmdValid && !cmdReady && !feResetStb_ff |=> cmdValid; endproperty
  a_holdValid: assert property (p_holdValid) else $error("word lost unread");
endmodule // fcd_deser_checker
bind fcd_deserializer fcd_deser_checker chk_u (.clk(clk), .arst_n(arst_n), .termCfg(termCfg),
  .termOn_ff(termOn_ff), .mainTick_ff(mainTick_ff), .loopWord_ff(loopWord_ff),
  .cmdDelay(cmdDelay), .calibStb_ff(calibStb_ff), .syncStb_ff(syncStb_ff),
  .snapStb_ff(snapStb_ff), .vetoStb_ff(vetoStb_ff), .noSuppStb_ff(noSuppStb_ff),
  .hdrOnlyStb_ff(hdrOnlyStb_ff), .feResetStb_ff(feResetStb_ff),
  .bxResetStb_ff(bxResetStb_ff), .testPulse_ff(testPulse_ff), .ovfClear(ovfClear),
  .overflow_ff(overflow_ff), .cmdValid(cmdValid), .cmdReady(cmdReady), .bxid_ff(bxid_ff));
`default_nettype wire

// *** dv/fcd_cmd_source.sv ***
// command source model: one byte per main cycle, two bits per clk
// assumes taps are sampled by the receiver on the rising clk edge
`timescale 1ns/10ps
`default_nettype none
module fcd_cmd_source #(parameter NPH = 4) (
  input wire logic clk, // bit clock
  input wire logic arst_n, // reset, active low
  input wire logic [7:0] cmdByte, // next word to send
  input wire logic [1:0] goodPhase, // tap with a clean bit
  output logic [NPH-1:0] riseTaps, // rise slot line per phase
  output logic [NPH-1:0] fallTaps // fall slot line per phase
);
  logic [1:0] slot;
  logic [7:0] word;
  logic [NPH-1:0] badMask;
  // other phases see the inverse, so a wrong tap never reads right by luck
  assign badMask = ~({{(NPH-1){1'b0}}, 1'b1} << goodPhase);
  // four slots per word, msb leaves first on the rise slot
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot <= 2'd0;
      word <= 8'h00;
    end else begin
      slot <= slot + 2'd1;
      if (slot == 2'd3) word <= cmdByte;
    end
  end
  assign riseTaps = {NPH{word[3'd7 - {slot, 1'b0}]}} ^ badMask;
  assign fallTaps = {NPH{word[3'd6 - {slot, 1'b0}]}} ^ badMask;
endmodule // fcd_cmd_source
`default_nettype wire

// *** dv/fcd_deserializer_tb.sv ***
// self-checking bench for the fast command deserializer
// assumes the source model and the bound checker are compiled first
`timescale 1ns/10ps
`default_nettype none
module fcd_deserializer_tb;
  logic clk, arst_n, rEdge, fEdge, term, ovfClr, rdy;
  logic [3:0] rTap, fTap;
  logic [1:0] rSel, fSel;
  logic [2:0] bStart;
  logic [7:0] dly, cDly, src, word, data, stb;
  logic termOn, tick, pulse, valid, ovf;
  logic [11:0] bxid, bxSnap;
  logic [31:0] cCnt, cSnap;
  int errCount = 0, checks = 0, cyc = 0, n, hits, found;
  fcd_cmd_source src_u (.clk(clk), .arst_n(arst_n), .cmdByte(src), .goodPhase(2'd2),
    .riseTaps(rTap), .fallTaps(fTap));
  fcd_deserializer dut_u (.clk(clk), .arst_n(arst_n), .riseTaps(rTap), .fallTaps(fTap),
    .risePhaseSel(rSel), .fallPhaseSel(fSel), .riseEdgeSel(rEdge), .fallEdgeSel(fEdge),
    .byteStart(bStart), .cmdDelay(dly), .calDelay(cDly), .termCfg(term), .ovfClear(ovfClr),
    .cmdReady(rdy), .termOn_ff(termOn), .loopWord_ff(word), .mainTick_ff(tick),
    .calibStb_ff(stb[7]), .syncStb_ff(stb[6]), .snapStb_ff(stb[5]), .vetoStb_ff(stb[4]),
    .noSuppStb_ff(stb[3]), .hdrOnlyStb_ff(stb[2]), .feResetStb_ff(stb[1]),
    .bxResetStb_ff(stb[0]), .testPulse_ff(pulse), .cmdData(data), .cmdValid(valid),
    .overflow_ff(ovf), .bxid_ff(bxid), .calibCnt_ff(cCnt), .calibSnap_ff(cSnap),
    .bxidSnap_ff(bxSnap));
  task automatic finishTest;
    if (errCount == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errCount++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // step to the falling edge after each main tick
  task automatic main(input int k);
    repeat (k) begin
      @(negedge clk);
      while (tick !== 1'b1) @(negedge clk);
    end
  endtask
  // one word for exactly one main cycle, then wait until it arrives
  task automatic send(input logic [7:0] b);
    main(1);
    src = b;
    main(1);
    src = 8'h00;
    n = 0;
    while (word !== b && n < 20) begin
      main(1);
      n++;
    end
  endtask
  // byte start search, as the controller does through loopback
  task automatic alignRun;
    hits = 0;
    src = 8'h1D;
    for (int i = 0; i < 8; i++) begin
      bStart = i[2:0];
      main(4);
      if (word === 8'h1D) begin
        hits++;
        found = i;
      end
    end
    chk("alignHits", hits, 1);
    bStart = found[2:0];
    rEdge = 1'b1;
    fEdge = 1'b1;
    main(4);
    // falling retimers are one clk sooner, so the byte moves two bits earlier
    chk("edgeSel", word, 8'h74);
    rEdge = 1'b0;
    fEdge = 1'b0;
    src = 8'h00;
  endtask
  task automatic delayRun(input logic [7:0] d);
    dly = d;
    main(d + 3);
    send(8'h20);
    n = 0;
    while (stb[5] !== 1'b1 && n < 300) begin
      main(1);
      n++;
    end
    chk("delay", n, d);
    main(1);
    chk("snapWidth", stb[5], 0);
  endtask
  task automatic calibRun;
    logic [31:0] c0;
    int a, t;
    dly = 8'h02;
    cDly = 8'h05;
    main(8);
    c0 = cCnt;
    send(8'h80);
    a = -1;
    t = -1;
    for (int i = 0; i < 8; i++) begin
      if (stb[7] === 1'b1 && a < 0) a = i;
      if (pulse === 1'b1 && t < 0) t = i;
      main(1);
    end
    chk("calibDelay", a, 2);
    chk("pulseDelay", t, 5);
    chk("calibCnt", cCnt, c0 + 1);
  endtask
  task automatic decodeRun;
    dly = 8'h00;
    main(4);
    for (int i = 7; i >= 0; i--) begin
      send(8'h01 << i);
      chk("strobes", stb, 8'h01 << i);
      main(2);
      if (i == 5) chk("snap", cSnap, cCnt);
      if (i == 5) chk("bxSnap", bxSnap, 12'(bxid - 12'h003));
      if (i == 1) chk("feReset", cCnt, 0);
      if (i == 0) chk("bxid", bxid <= 12'h003, 1);
    end
  endtask
  // fill to the brim with the drain stalled, then empty it
  task automatic fifoRun;
    rdy = 1'b1;
    src = 8'h44;
    ovfClr = 1'b1;
    main(8);
    rdy = 1'b0;
    ovfClr = 1'b0;
    chk("empty", valid, 0);
    // sixteen buffered words plus the registered head word
    main(17);
    chk("fullNoOvf", ovf, 0);
    chk("head", data, 8'h44);
    main(1);
    chk("ovf", ovf, 1);
    rdy = 1'b1;
    n = 0;
    while (valid === 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("pops", n >= 16, 1);
    ovfClr = 1'b1;
    @(negedge clk);
    ovfClr = 1'b0;
    chk("ovfClr", ovf, 0);
  endtask
  task automatic phaseRun;
    src = 8'h1D;
    rSel = 2'd3;
    main(4);
    chk("risePath", word, 8'hB7);
    rSel = 2'd2;
    fSel = 2'd0;
    main(4);
    chk("fallPath", word, 8'h48);
    fSel = 2'd2;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // hang guard, about seven times the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      errCount++;
      finishTest;
    end
  end
  initial begin
    {arst_n, rEdge, fEdge, term, ovfClr, rdy, bStart, dly, cDly, src} = '0;
    rSel = 2'd2;
    fSel = 2'd2;
    repeat (3) @(negedge clk);
    chk("rstTerm", termOn, 0);
    chk("rstStb", stb, 0);
    arst_n = 1'b1;
    term = 1'b1;
    main(1);
    chk("termOn", termOn, 1);
    term = 1'b0;
    alignRun;
    delayRun(8'hFF);
    delayRun(8'h01);
    delayRun(8'h00);
    calibRun;
    decodeRun;
    fifoRun;
    phaseRun;
    finishTest;
  end
endmodule // fcd_deserializer_tb
`default_nettype wire
